// [dapr_defs.svh]
// Purpose: shared numbers for the dual converter readout block
// Assumes: 12-bit results, conversion clock at sixteen times sample rate
// Notes:   timing figures in ns, cycle counts derived from the clk_sys rate
`ifndef DAPR_DEFS_SVH
`define DAPR_DEFS_SVH

`define DAPR_RESULT_W        12
`define DAPR_CLKS_PER_SAMPLE 16
`define DAPR_SYS_PERIOD_NS   4
`define DAPR_START_MIN_NS    15
// least time rounds up to whole system cycles
`define DAPR_START_MIN_CYC   \
  ((`DAPR_START_MIN_NS + `DAPR_SYS_PERIOD_NS - 1) / `DAPR_SYS_PERIOD_NS)
`define DAPR_SYNC_STAGES     2
`define DAPR_RESULT_RST      12'h000

// positions of the synchronised pins inside the pin group
`define DAPR_PIN_START       0
`define DAPR_PIN_SELECT      1
`define DAPR_PIN_CONV_CLK    2
`define DAPR_PIN_CS          3
`define DAPR_PIN_RD          4
`define DAPR_PIN_COUNT       5

`endif

// [dapr_pkg.sv]
// Purpose: types shared by the readout block
// Assumes: nothing beyond the defs header
// Notes:   gray code along idle -> convert -> idle
package dapr_pkg;
  typedef enum logic [1:0]
  {
    DAPR_IDLE    = 2'h0,
    DAPR_CONVERT = 2'h1
  } dapr_state_e;

  typedef logic [11:0] dapr_word_t;
endpackage

// [dapr_pin_if.sv]
// Purpose: carries synchronised pin levels and their edges
// Assumes: all members on clk_sys
// Notes:   edges are one-cycle pulses
interface dapr_pin_if #(
  parameter int W = 5
);
  logic [W-1:0] level;
  logic [W-1:0] fall;
  logic [W-1:0] rise;

  modport src (output level, output fall, output rise);
  modport dst (input level, input fall, input rise);
endinterface

// [dapr_pin_sync.sv]
// Purpose: two-flop synchroniser and edge finder per pin
// Assumes: pins are asynchronous to clk_sys
// Notes:   first stage is read only by the second stage
module dapr_pin_sync #(
  parameter int W = 5
)(
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_in,
  dapr_pin_if.src           pins
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] s1_d;
  logic [W-1:0] s2_d;
  logic [W-1:0] s3_d;

  // next values: shift each pin one stage per edge
  always_comb
  begin
    s1_d = pin_in;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  // idle-high reset keeps strobes from faking an edge after release
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  // edges seen only between second and third stage
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_edge
      assign pins.level[i] = s2_q[i];
      assign pins.fall[i]  = s3_q[i] & ~s2_q[i];
      assign pins.rise[i]  = ~s3_q[i] & s2_q[i];
    end
  endgenerate
endmodule

// [dapr_top.sv]
// Purpose: conversion control and parallel readout of a dual converter
// Assumes: conversion clock well below a quarter of clk_sys
// Notes:   conversion codes arrive from the converter cores on clk_sys
//
// Contract
// - busy is high exactly while a conversion runs, low otherwise.
// - pair select sampled at start strobe fall picks input 0 or 1.
// - conversion advances on the external clock, sixteen clocks per sample.
// - first read strobe fall shows converter A, second shows converter B.
// - select level during read picks input 0 or 1 result.
// - start strobe fall while idle puts both holds in hold and starts both converters.
// - bus is driven only while chip select and read strobe are both low.
`include "dapr_defs.svh"

module dapr_top
  import dapr_pkg::*;
#(
  parameter int CLKS_PER_SAMPLE = `DAPR_CLKS_PER_SAMPLE
)(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        conversion_start_strobe_n,
  input  wire logic        pair_select,
  input  wire logic        conv_clk,
  input  wire logic        chip_select_n,
  input  wire logic        read_strobe_n,
  input  wire logic [11:0] code_a0,
  input  wire logic [11:0] code_a1,
  input  wire logic [11:0] code_b0,
  input  wire logic [11:0] code_b1,
  output logic             busy,
  output logic [11:0]      result_out,
  output logic             result_oe
);
  // counter must hold the full per-sample clock count
  localparam int CW = $clog2(CLKS_PER_SAMPLE + 1);
  localparam logic [CW-1:0] LAST_CLK = CW'(CLKS_PER_SAMPLE);

  dapr_pin_if #(.W(`DAPR_PIN_COUNT)) pins ();

  // raw pin levels gathered in the order the sync stages expect
  logic [`DAPR_PIN_COUNT-1:0] pin_raw;

  // pin order fixed by the defs header
  assign pin_raw[`DAPR_PIN_START]    = conversion_start_strobe_n;
  assign pin_raw[`DAPR_PIN_SELECT]   = pair_select;
  assign pin_raw[`DAPR_PIN_CONV_CLK] = conv_clk;
  assign pin_raw[`DAPR_PIN_CS]       = chip_select_n;
  assign pin_raw[`DAPR_PIN_RD]       = read_strobe_n;

  // every pin crosses into clk_sys through two flops before any logic
  dapr_pin_sync #(.W(`DAPR_PIN_COUNT)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pin_in  (pin_raw),
    .pins    (pins)
  );

  // edge and level views of the synchronised pins; the read edge only
  // counts with chip select low, so strobes without select are refused
  logic start_fall;
  logic sel_lvl;
  logic cclk_rise;
  logic access_lvl;
  logic rd_fall;
  logic cs_rise;

  assign start_fall = pins.fall[`DAPR_PIN_START];
  assign sel_lvl    = pins.level[`DAPR_PIN_SELECT];
  assign cclk_rise  = pins.rise[`DAPR_PIN_CONV_CLK];
  assign access_lvl = ~pins.level[`DAPR_PIN_CS] & ~pins.level[`DAPR_PIN_RD];
  assign rd_fall    = pins.fall[`DAPR_PIN_RD] & ~pins.level[`DAPR_PIN_CS];
  assign cs_rise    = pins.rise[`DAPR_PIN_CS];

  // conversion state
  dapr_state_e  state_q;
  dapr_state_e  state_d;
  logic [CW-1:0] clk_cnt_q;
  logic [CW-1:0] clk_cnt_d;
  logic          pair_q;
  logic          pair_d;
  dapr_word_t    hold_a_q;
  dapr_word_t    hold_a_d;
  dapr_word_t    hold_b_q;
  dapr_word_t    hold_b_d;
  logic          busy_q;
  logic          busy_d;
  // result store, index 0 = input 0, index 1 = input 1
  dapr_word_t    res_a_q [2];
  dapr_word_t    res_a_d [2];
  dapr_word_t    res_b_q [2];
  dapr_word_t    res_b_d [2];

  // next values of the conversion sequencer
  always_comb
  begin
    state_d   = state_q;
    clk_cnt_d = clk_cnt_q;
    pair_d    = pair_q;
    hold_a_d  = hold_a_q;
    hold_b_d  = hold_b_q;
    busy_d    = busy_q;
    res_a_d   = res_a_q;
    res_b_d   = res_b_q;
    case (state_q)
      DAPR_IDLE:
      begin
        if (start_fall)
        begin
          pair_d    = sel_lvl;
          hold_a_d  = sel_lvl ? code_a1 : code_a0;
          hold_b_d  = sel_lvl ? code_b1 : code_b0;
          clk_cnt_d = '0;
          busy_d    = 1'b1;
          state_d   = DAPR_CONVERT;
        end
      end
      DAPR_CONVERT:
      begin
        // start strobes while converting are ignored: both holds are busy
        if (cclk_rise)
        begin
          // last counted rise closes the sample: publish both words at once
          if (clk_cnt_q == LAST_CLK - CW'(1))
          begin
            res_a_d[pair_q] = hold_a_q;
            res_b_d[pair_q] = hold_b_q;
            busy_d          = 1'b0;
            state_d         = DAPR_IDLE;
          end
          else
          begin
            clk_cnt_d = clk_cnt_q + CW'(1);
          end
        end
      end
      // unused code: recover to idle rather than lock up
      default:
      begin
        state_d = DAPR_IDLE;
        busy_d  = 1'b0;
      end
    endcase
  end

  // register the sequencer; reset parks it idle with cleared stores
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_q    <= DAPR_IDLE;
      clk_cnt_q  <= '0;
      pair_q     <= 1'b0;
      hold_a_q   <= `DAPR_RESULT_RST;
      hold_b_q   <= `DAPR_RESULT_RST;
      busy_q     <= 1'b0;
      res_a_q[0] <= `DAPR_RESULT_RST;
      res_a_q[1] <= `DAPR_RESULT_RST;
      res_b_q[0] <= `DAPR_RESULT_RST;
      res_b_q[1] <= `DAPR_RESULT_RST;
    end
    else
    begin
      state_q   <= state_d;
      clk_cnt_q <= clk_cnt_d;
      pair_q    <= pair_d;
      hold_a_q  <= hold_a_d;
      hold_b_q  <= hold_b_d;
      busy_q    <= busy_d;
      res_a_q   <= res_a_d;
      res_b_q   <= res_b_d;
    end
  end

  // readout state
  logic       ptr_b_q;
  logic       ptr_b_d;
  dapr_word_t data_q;
  dapr_word_t data_d;
  logic       oe_q;
  logic       oe_d;

  // read pointer restarts at A when chip select goes away, so each
  // access opens with the A word even after an odd number of strobes
  always_comb
  begin
    ptr_b_d = ptr_b_q;
    data_d  = data_q;
    oe_d    = access_lvl;
    if (rd_fall)
    begin
      data_d  = ptr_b_q ? res_b_q[sel_lvl]
                        : res_a_q[sel_lvl];
      ptr_b_d = ~ptr_b_q;
    end
    // chip select going away restarts the A then B order
    else if (cs_rise)
    begin
      ptr_b_d = 1'b0;
    end
  end

  // register the readout; after reset the bus is released, pointer at A
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ptr_b_q <= 1'b0;
      data_q  <= `DAPR_RESULT_RST;
      oe_q    <= 1'b0;
    end
    else
    begin
      ptr_b_q <= ptr_b_d;
      data_q  <= data_d;
      oe_q    <= oe_d;
    end
  end

  // outputs straight from flops
  assign busy       = busy_q;
  assign result_out = data_q;
  assign result_oe  = oe_q;
endmodule

// [dapr_top_asserts.sv]
// Purpose: port checks for the readout block
// Assumes: pins move just after clk_sys edges
// Notes:   pin sync takes about three edges
module dapr_top_asserts #(
  parameter int CLKS_PER_SAMPLE = 16
)(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        conversion_start_strobe_n,
  input wire logic        conv_clk,
  input wire logic        chip_select_n,
  input wire logic        read_strobe_n,
  input wire logic        busy,
  input wire logic [11:0] result_out,
  input wire logic        result_oe
);
  // one domain, so clock and reset gate are shared
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  start_busy_a: assert property (
    $fell(conversion_start_strobe_n) && !busy |-> ##[1:5] busy)
    else $error("no busy after start");
  busy_cause_a: assert property (
    $rose(busy) |-> !$past(conversion_start_strobe_n, 2))
    else $error("busy without start");
  busy_min_a: assert property (
    $rose(busy) |-> busy[*8])
    else $error("conversion too short");
  busy_end_a: assert property (
    $fell(busy) |-> $past(conv_clk, 2))
    else $error("busy end without clock");
  bus_on_a: assert property (
    (!chip_select_n && !read_strobe_n)[*4] |-> result_oe)
    else $error("bus not driven");
  bus_off_a: assert property (
    (chip_select_n || read_strobe_n)[*4] |-> !result_oe)
    else $error("bus driven when idle");
  word_cause_a: assert property (
    $changed(result_out) |-> !$past(read_strobe_n, 2))
    else $error("word moved without read");
  // reset gate off here: this one watches the reset itself
  reset_vals_a: assert property (disable iff (1'h0)
    !rst_n |=> !busy && !result_oe && result_out == 12'h000)
    else $error("bad reset values");
endmodule

bind dapr_top dapr_top_asserts #(.CLKS_PER_SAMPLE(CLKS_PER_SAMPLE)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n),
  .conversion_start_strobe_n(conversion_start_strobe_n),
  .conv_clk(conv_clk), .chip_select_n(chip_select_n),
  .read_strobe_n(read_strobe_n), .busy(busy),
  .result_out(result_out), .result_oe(result_oe));

// [dapr_host.sv]
// Purpose: host model driving the converter pins
// Assumes: tasks called from the bench thread
// Notes:   conversion clock parked low between frames
module dapr_host (
  input wire logic clk_sys,
  output logic     start_n,
  output logic     sel,
  output logic     cclk,
  output logic     cs_n,
  output logic     rd_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // strobes idle high
  initial
  begin
    start_n = 1'h1;
    sel = 1'h0;
    cclk = 1'h0;
    cs_n = 1'h1;
    rd_n = 1'h1;
  end
  // select settles a cycle early, start low 16 ns
  task automatic start(input logic s);
    @(posedge clk_sys);
    sel <= s;
    @(posedge clk_sys);
    start_n <= 1'h0;
    repeat (4) @(posedge clk_sys);
    start_n <= 1'h1;
  endtask
  // sixteen periods of eight cycles, only inside a frame
  task automatic conv();
    repeat (16)
    begin
      @(posedge clk_sys);
      cclk <= 1'h1;
      repeat (4) @(posedge clk_sys);
      cclk <= 1'h0;
      repeat (3) @(posedge clk_sys);
    end
  endtask
  // select and chip select lead the strobe by a cycle
  task automatic rd_lo(input logic s);
    @(posedge clk_sys);
    cs_n <= 1'h0;
    sel <= s;
    @(posedge clk_sys);
    rd_n <= 1'h0;
    repeat (5) @(posedge clk_sys);
  endtask
  task automatic rd_hi(input logic e);
    @(posedge clk_sys);
    rd_n <= 1'h1;
    cs_n <= e;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule

// [dapr_bench.sv]
// Purpose: self-checking bench for the readout block
// Assumes: host model owns every pin
// Notes:   fixed codes, msb set in some to show bit order
module dapr_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dapr_pkg::*;
  logic       clk_sys;
  logic       rst_n;
  logic       st_n, sel, cclk, cs_n, rd_n;
  logic       busy;
  logic       oe;
  dapr_word_t res;
  dapr_word_t code [4] = '{12'h801, 12'h0F2, 12'hA53, 12'h3C4};
  int         failures = 0;
  int         n_tests = 0;

  dapr_host host (.clk_sys(clk_sys), .start_n(st_n), .sel(sel),
    .cclk(cclk), .cs_n(cs_n), .rd_n(rd_n));
  dapr_top uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .conversion_start_strobe_n(st_n), .pair_select(sel),
    .conv_clk(cclk), .chip_select_n(cs_n), .read_strobe_n(rd_n),
    .code_a0(code[0]), .code_a1(code[1]), .code_b0(code[2]),
    .code_b1(code[3]), .busy(busy), .result_out(res),
    .result_oe(oe));
  // 4 ns clock
  initial
  begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic chk_b(string n, logic e, logic g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic chk_w(string n, dapr_word_t e, dapr_word_t g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // reset values hold at the first edge after release
  task automatic t_power_on();
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    #1;
    chk_b("busy", 1'h0, busy);
    chk_w("word", 12'h000, res);
    $display("reset test done");
  endtask
  task automatic t_conv(input logic s);
    host.start(s);
    #1;
    chk_b("busy", 1'h1, busy);
    host.conv();
    #1;
    chk_b("busy", 1'h0, busy);
    $display("conv test done");
  endtask
  // A, B, then A again; select at read picks the pair
  task automatic t_read(input logic s);
    host.rd_lo(s);
    #1;
    chk_b("oe", 1'h1, oe);
    chk_w("word a", code[s], res);
    host.rd_hi(1'h0);
    host.rd_lo(s);
    #1;
    chk_w("word b", code[2+s], res);
    host.rd_hi(1'h0);
    host.rd_lo(s);
    #1;
    chk_w("word a", code[s], res);
    host.rd_hi(1'h1);
    #1;
    chk_b("oe", 1'h0, oe);
    $display("read test done");
  endtask
  // codes and select move after the start fall, and a second start
  // comes while busy: pair 0 must still return the codes held at start
  task automatic t_hold();
    @(posedge clk_sys);
    code[0] <= 12'h7FE;
    code[2] <= 12'h01D;
    host.start(1'h0);
    code[0] <= 12'h555;
    code[2] <= 12'hAAA;
    host.start(1'h1);
    host.conv();
    #1;
    chk_b("busy", 1'h0, busy);
    host.rd_lo(1'h0);
    #1;
    chk_w("held a", 12'h7FE, res);
    host.rd_hi(1'h0);
    host.rd_lo(1'h0);
    #1;
    chk_w("held b", 12'h01D, res);
    host.rd_hi(1'h1);
    $display("hold test done");
  endtask
  // reset in mid conversion drops busy and clears the stored A word of input 1
  task automatic t_midreset();
    host.start(1'h1);
    #1;
    chk_b("busy", 1'h1, busy);
    @(posedge clk_sys);
    rst_n <= 1'h0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    #1;
    chk_b("busy", 1'h0, busy);
    chk_w("word", 12'h000, res);
    host.rd_lo(1'h1);
    #1;
    chk_b("oe", 1'h1, oe);
    chk_w("stored a", 12'h000, res);
    host.rd_hi(1'h1);
    $display("mid reset test done");
  endtask
  initial
  begin
    rst_n = 1'h0;
    t_power_on();
    t_conv(1'h0);
    t_conv(1'h1);
    t_read(1'h0);
    t_read(1'h1);
    t_hold();
    t_midreset();
    close_out();
  end
  // tests need some 600 cycles; a hang stops well after
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    failures++;
    close_out();
  end
endmodule
